// >>> src/adc_seq_pkg.sv
// Shared constants, field layouts and types of the converter sequence control block
package adc_seq_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h0C;
    localparam logic [7:0] OFS_ENGINE_STATUS = 8'h10;

    // Control one field positions
    localparam int C1_DONE = 0;
    localparam int C1_SAMPLE = 1;
    localparam int C1_AUTO = 2;
    localparam int C1_TRIG_LO = 5;
    localparam int C1_TWELVE = 10;

    // Control two field positions
    localparam int C2_ALT = 0;
    localparam int C2_FILL = 1;
    localparam int C2_SEQ_LO = 2;
    localparam int C2_BUF_HALF = 7;
    localparam int C2_CHAN_LO = 8;
    localparam int C2_SCAN = 10;
    localparam int C2_REF_LO = 13;

    // Event bits of the status and mask registers
    localparam int EVT_DONE = 0;
    localparam int EVT_INTERVAL = 1;
    localparam int EVT_W = 2;

    // Trigger source codes
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_PIN = 3'h1;
    localparam logic [2:0] TRIG_TIMER = 3'h2;
    localparam logic [2:0] TRIG_INTERNAL = 3'h7;

    // Reference codes
    localparam logic [2:0] REF_EXT_HIGH = 3'h1;
    localparam logic [2:0] REF_EXT_LOW = 3'h2;
    localparam logic [2:0] REF_EXT_BOTH = 3'h3;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [1:0] CHAN_ONE = 2'h0;
    localparam logic [1:0] CHAN_TWO = 2'h1;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} state_t;

    typedef struct packed {
        logic twelve_bit_mode;
        logic [2:0] conversion_trigger_source;
        logic auto_sample_start;
    } ctrl_one_t;

    typedef struct packed {
        logic [2:0] reference_config;
        logic input_scan_select;
        logic [1:0] channel_count_select;
        logic [3:0] sequences_per_interrupt;
        logic buffer_fill_mode;
        logic alternate_input_select;
    } ctrl_two_t;

    // Number of sample-and-hold channels converted per sequence
    function automatic logic [2:0] channels_used(input logic twelve, input logic [1:0] sel);
        if (twelve || sel == CHAN_ONE) begin
            return 3'h1;
        end else if (sel == CHAN_TWO) begin
            return 3'h2;
        end
        return 3'h4;
    endfunction
endpackage

// >>> src/adc_phase_timer.sv
// Down counter that times the sampling and conversion phases
`timescale 1ns/10ps
`default_nettype none
module adc_phase_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_value,
    // Result
    output logic expired
);
    logic [W-1:0] count;
    logic running;

    // Load restarts the count; expiry is a one-cycle pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                count <= load_value;
                running <= 1'b1;
            end else if (running) begin
                count <= count - 1'b1;
                if (count <= W'(1)) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/adc_sequence_counter.sv
// Counts sample/convert sequences, paces the interrupt and tracks the buffer half
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_counter (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Sequence events and settings
    input wire logic tick,
    input wire logic [3:0] interval,
    input wire logic fill_mode,
    // Results
    output logic interval_pulse,
    output logic buffer_half,
    output logic [3:0] seq_index
);
    // Interval reached after interval+1 sequences, then restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_index <= '0;
            interval_pulse <= 1'b0;
        end else begin
            interval_pulse <= 1'b0;
            if (tick) begin
                if (seq_index >= interval) begin
                    seq_index <= '0;
                    interval_pulse <= 1'b1;
                end else begin
                    seq_index <= seq_index + 4'h1;
                end
            end
        end
    end

    // Half swaps at each interrupt in split mode, else stays at the start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buffer_half <= 1'b0;
        end else if (!fill_mode) begin
            buffer_half <= 1'b0;
        end else if (tick && seq_index >= interval) begin
            buffer_half <= ~buffer_half;
        end
    end
endmodule
`default_nettype wire

// >>> src/adc_sequence_control.sv
// Converter sequence control: sampling, conversion handshake, status and AXI4-Lite registers
//
// Contract
// - Auto start resamples after conversion, sets enable
// - Without auto start, sampling waits for enable
// - Sample enable reads one while sampling
// - Software writing one starts sampling manually
// - Manual trigger: writing zero starts conversion
// - Other triggers: hardware clears enable, converts
// - Complete flag set when conversion finishes
// - Complete flag cleared when conversion starts
// - Software clears flag only; nothing disturbed
// - Reference field selects supply or external
// - Buffer half status read-only, resets zero
// - Four-bit field sets sequences per interrupt
// - Split fill alternates halves, else restarts
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_control #(
    parameter int SAMPLE_CYCLES = 4,
    parameter int CONVERT_CYCLES = 14,
    parameter int TW = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Conversion triggers
    input wire logic trigger_pin,
    input wire logic timer_compare_event,
    // Analog front end control
    output logic sampling,
    output logic converting,
    output logic ref_high_external,
    output logic ref_low_external,
    output logic [2:0] channels_converted,
    output logic second_input_set,
    output logic buffer_half,
    // Interrupt
    output logic irq
);
    adc_seq_pkg::ctrl_one_t ctrl_one;
    adc_seq_pkg::ctrl_two_t ctrl_two;
    adc_seq_pkg::state_t state;
    logic sample_enable;
    logic done;
    logic next_sample_enable;
    logic [adc_seq_pkg::EVT_W-1:0] event_status;
    logic [adc_seq_pkg::EVT_W-1:0] event_mask;
    logic aw_held;
    logic w_held;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic wr_one;
    logic wr_two;
    logic [15:0] wr_one_data;
    logic [15:0] wr_two_data;
    logic [15:0] rd_one;
    logic [15:0] rd_two;
    logic pin_meta;
    logic pin_sync;
    logic pin_last;
    logic hw_end;
    logic start_sample;
    logic start_conv;
    logic conv_finish;
    logic timer_load;
    logic [TW-1:0] timer_value;
    logic timer_expired;
    logic interval_pulse;
    logic [3:0] seq_index;
    logic [2:0] nch;

    // Merge bytes of a write into a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    assign nch = adc_seq_pkg::channels_used(ctrl_one.twelve_bit_mode,
                                            ctrl_two.channel_count_select);

    // Phase timer and sequence counter
    adc_phase_timer #(.W(TW)) phase_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(timer_load),
        .load_value(timer_value),
        .expired(timer_expired)
    );

    adc_sequence_counter seq_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(conv_finish),
        .interval(ctrl_two.sequences_per_interrupt),
        .fill_mode(ctrl_two.buffer_fill_mode),
        .interval_pulse(interval_pulse),
        .buffer_half(buffer_half),
        .seq_index(seq_index)
    );

    // Trigger pin synchroniser and edge detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_last <= 1'b0;
        end else begin
            pin_meta <= trigger_pin;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    // Hardware end-of-sample event for the selected trigger source
    always_comb begin
        unique case (ctrl_one.conversion_trigger_source)
            adc_seq_pkg::TRIG_PIN: hw_end = pin_sync && !pin_last;
            adc_seq_pkg::TRIG_TIMER: hw_end = timer_compare_event;
            adc_seq_pkg::TRIG_INTERNAL: hw_end = timer_expired;
            default: hw_end = 1'b0;
        endcase
    end

    // Write path strobes
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_one = wr_fire && wr_addr == adc_seq_pkg::OFS_CONTROL_ONE && wr_strb[0];
    assign wr_two = wr_fire && wr_addr == adc_seq_pkg::OFS_CONTROL_TWO;
    assign wr_one_data = merge(rd_one, wr_data, wr_strb);
    assign wr_two_data = merge(rd_two, wr_data, wr_strb);
    assign conv_finish = state == adc_seq_pkg::ST_CONVERT && timer_expired;

    // Next value of the sample-enable bit
    always_comb begin
        next_sample_enable = sample_enable;
        if (ctrl_one.auto_sample_start) begin
            if (conv_finish || state == adc_seq_pkg::ST_IDLE) begin
                next_sample_enable = 1'b1;
            end
        end else if (state == adc_seq_pkg::ST_IDLE && wr_one
                     && wr_data[adc_seq_pkg::C1_SAMPLE]) begin
            next_sample_enable = 1'b1;
        end
        if (state == adc_seq_pkg::ST_SAMPLE) begin
            if (ctrl_one.conversion_trigger_source == adc_seq_pkg::TRIG_MANUAL) begin
                if (wr_one && !wr_data[adc_seq_pkg::C1_SAMPLE]) begin
                    next_sample_enable = 1'b0;
                end
            end else if (hw_end) begin
                next_sample_enable = 1'b0;
            end
        end
    end

    assign start_sample = state != adc_seq_pkg::ST_SAMPLE && next_sample_enable;
    assign start_conv = state == adc_seq_pkg::ST_SAMPLE && !next_sample_enable;
    assign timer_load = start_sample || start_conv;
    assign timer_value = start_conv ? TW'(CONVERT_CYCLES * nch) : TW'(SAMPLE_CYCLES);

    // Sequencer state and sample-enable bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= adc_seq_pkg::ST_IDLE;
            sample_enable <= 1'b0;
        end else begin
            sample_enable <= next_sample_enable;
            if (start_conv) begin
                state <= adc_seq_pkg::ST_CONVERT;
            end else if (start_sample) begin
                state <= adc_seq_pkg::ST_SAMPLE;
            end else if (conv_finish) begin
                state <= adc_seq_pkg::ST_IDLE;
            end
        end
    end

    // Conversion-complete flag; the hardware set wins over any clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done <= 1'b0;
        end else if (conv_finish) begin
            done <= 1'b1;
        end else if (start_conv) begin
            done <= 1'b0;
        end else if (wr_one && !wr_data[adc_seq_pkg::C1_DONE]) begin
            done <= 1'b0;
        end
    end

    // Control register storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_one <= '0;
            ctrl_two <= '0;
        end else begin
            if (wr_fire && wr_addr == adc_seq_pkg::OFS_CONTROL_ONE) begin
                ctrl_one.auto_sample_start <= wr_one_data[adc_seq_pkg::C1_AUTO];
                ctrl_one.conversion_trigger_source <= wr_one_data[adc_seq_pkg::C1_TRIG_LO +: 3];
                ctrl_one.twelve_bit_mode <= wr_one_data[adc_seq_pkg::C1_TWELVE];
            end
            if (wr_two) begin
                ctrl_two.reference_config <= wr_two_data[adc_seq_pkg::C2_REF_LO +: 3];
                ctrl_two.input_scan_select <= wr_two_data[adc_seq_pkg::C2_SCAN];
                ctrl_two.channel_count_select <= wr_two_data[adc_seq_pkg::C2_CHAN_LO +: 2];
                ctrl_two.sequences_per_interrupt <= wr_two_data[adc_seq_pkg::C2_SEQ_LO +: 4];
                ctrl_two.buffer_fill_mode <= wr_two_data[adc_seq_pkg::C2_FILL];
                ctrl_two.alternate_input_select <= wr_two_data[adc_seq_pkg::C2_ALT];
            end
        end
    end

    // Event status (write one to clear, set wins) and mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_status <= '0;
            event_mask <= '0;
        end else begin
            if (wr_fire && wr_addr == adc_seq_pkg::OFS_EVENT_STATUS && wr_strb[0]) begin
                event_status <= (event_status & ~wr_data[adc_seq_pkg::EVT_W-1:0])
                                | {interval_pulse, conv_finish};
            end else begin
                event_status <= event_status | {interval_pulse, conv_finish};
            end
            if (wr_fire && wr_addr == adc_seq_pkg::OFS_EVENT_MASK && wr_strb[0]) begin
                event_mask <= wr_data[adc_seq_pkg::EVT_W-1:0];
            end
        end
    end

    // Front end outputs and interrupt, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sampling <= 1'b0;
            converting <= 1'b0;
            ref_high_external <= 1'b0;
            ref_low_external <= 1'b0;
            channels_converted <= 3'h1;
            second_input_set <= 1'b0;
            irq <= 1'b0;
        end else begin
            sampling <= next_sample_enable;
            converting <= start_conv || (state == adc_seq_pkg::ST_CONVERT && !conv_finish);
            ref_high_external <= ctrl_two.reference_config == adc_seq_pkg::REF_EXT_HIGH
                || ctrl_two.reference_config == adc_seq_pkg::REF_EXT_BOTH;
            ref_low_external <= ctrl_two.reference_config == adc_seq_pkg::REF_EXT_LOW
                || ctrl_two.reference_config == adc_seq_pkg::REF_EXT_BOTH;
            channels_converted <= nch;
            if (!ctrl_two.alternate_input_select) begin
                second_input_set <= 1'b0;
            end else if (start_conv) begin
                second_input_set <= ~second_input_set;
            end
            irq <= |(event_status & event_mask);
        end
    end

    // Register read images
    always_comb begin
        rd_one = '0;
        rd_one[adc_seq_pkg::C1_DONE] = done;
        rd_one[adc_seq_pkg::C1_SAMPLE] = sample_enable;
        rd_one[adc_seq_pkg::C1_AUTO] = ctrl_one.auto_sample_start;
        rd_one[adc_seq_pkg::C1_TRIG_LO +: 3] = ctrl_one.conversion_trigger_source;
        rd_one[adc_seq_pkg::C1_TWELVE] = ctrl_one.twelve_bit_mode;
        rd_two = '0;
        rd_two[adc_seq_pkg::C2_REF_LO +: 3] = ctrl_two.reference_config;
        rd_two[adc_seq_pkg::C2_SCAN] = ctrl_two.input_scan_select;
        if (!ctrl_one.twelve_bit_mode) begin
            rd_two[adc_seq_pkg::C2_CHAN_LO +: 2] = ctrl_two.channel_count_select;
        end
        rd_two[adc_seq_pkg::C2_BUF_HALF] = buffer_half;
        rd_two[adc_seq_pkg::C2_SEQ_LO +: 4] = ctrl_two.sequences_per_interrupt;
        rd_two[adc_seq_pkg::C2_FILL] = ctrl_two.buffer_fill_mode;
        rd_two[adc_seq_pkg::C2_ALT] = ctrl_two.alternate_input_select;
    end

    // Write channels: address and data taken in either order, then respond
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= adc_seq_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                unique case (wr_addr)
                    adc_seq_pkg::OFS_CONTROL_ONE, adc_seq_pkg::OFS_CONTROL_TWO,
                    adc_seq_pkg::OFS_EVENT_STATUS, adc_seq_pkg::OFS_EVENT_MASK,
                    adc_seq_pkg::OFS_ENGINE_STATUS: s_axi_bresp <= adc_seq_pkg::RESP_OKAY;
                    default: s_axi_bresp <= adc_seq_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read under way, data one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= adc_seq_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= adc_seq_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    adc_seq_pkg::OFS_CONTROL_ONE: s_axi_rdata <= {16'h0000, rd_one};
                    adc_seq_pkg::OFS_CONTROL_TWO: s_axi_rdata <= {16'h0000, rd_two};
                    adc_seq_pkg::OFS_EVENT_STATUS: s_axi_rdata <= {30'h0000_0000, event_status};
                    adc_seq_pkg::OFS_EVENT_MASK: s_axi_rdata <= {30'h0000_0000, event_mask};
                    adc_seq_pkg::OFS_ENGINE_STATUS: s_axi_rdata <= {25'h000_0000, seq_index,
                        second_input_set, state == adc_seq_pkg::ST_CONVERT,
                        state == adc_seq_pkg::ST_SAMPLE};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= adc_seq_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/adc_seq_chk.sv
// Bus handshake and phase sequencing assertions for the converter sequence control block
`timescale 1ns/10ps
`default_nettype none
module adc_seq_chk #(
    parameter int CONVERT_CYCLES = 14
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Front end
    input wire logic sampling,
    input wire logic converting,
    input wire logic [2:0] channels_converted
);
    logic [7:0] conv_len;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Counts the cycles of the running conversion
    always_ff @(posedge aclk) begin
        if (!aresetn || !converting) begin
            conv_len <= 8'h00;
        end else begin
            conv_len <= conv_len + 8'h01;
        end
    end
    property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
    property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped early");
    property p_aw_blocked; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_aw_blocked: assert property (p_aw_blocked) else $error("write taken during response");
    property p_ar_blocked; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_blocked: assert property (p_ar_blocked) else $error("read taken during response");
    property p_phase_excl; !(sampling && converting); endproperty
    a_phase_excl: assert property (p_phase_excl) else $error("sampling while converting");
    property p_conv_after_sample; $rose(converting) |-> $past(sampling); endproperty
    a_conv_after_sample: assert property (p_conv_after_sample)
        else $error("conversion without sampling");
    property p_conv_len;
        $fell(converting) |-> conv_len == CONVERT_CYCLES * $past(channels_converted) + 1;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_chan_legal; channels_converted inside {3'h1, 3'h2, 3'h4}; endproperty
    a_chan_legal: assert property (p_chan_legal) else $error("channel count illegal");
endmodule
bind adc_sequence_control adc_seq_chk #(.CONVERT_CYCLES(CONVERT_CYCLES)) adc_seq_chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sampling(sampling),
    .converting(converting), .channels_converted(channels_converted));
`default_nettype wire

// >>> sim/adc_sequence_control_tb.sv
// Register level testbench of the converter sequence control block
`timescale 1ns/10ps
`default_nettype none
module adc_sequence_control_tb;
    localparam logic [7:0] C1 = adc_seq_pkg::OFS_CONTROL_ONE;
    localparam logic [7:0] C2 = adc_seq_pkg::OFS_CONTROL_TWO;
    localparam logic [7:0] EV = adc_seq_pkg::OFS_EVENT_STATUS;
    localparam logic [7:0] MK = adc_seq_pkg::OFS_EVENT_MASK;
    localparam logic [1:0] OK = adc_seq_pkg::RESP_OKAY;
    localparam logic [1:0] ER = adc_seq_pkg::RESP_SLVERR;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic trigger_pin = 0, timer_compare_event = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, sampling, converting, rhi, rlo, sis, bh, irq;
    logic [2:0] chans;
    logic prev;
    int bad_count = 0, checks = 0;
    adc_sequence_control #(.SAMPLE_CYCLES(3), .CONVERT_CYCLES(5), .TW(8)) adc_sequence_control_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trigger_pin(trigger_pin), .timer_compare_event(timer_compare_event),
        .sampling(sampling), .converting(converting), .ref_high_external(rhi),
        .ref_low_external(rlo), .channels_converted(chans), .second_input_set(sis),
        .buffer_half(bh), .irq(irq));
    // Clock at 200 MHz
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One write; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'h3; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (int k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        bready <= 0;
        chk("bvalid", 1, bvalid);
        chk("bresp", er, bresp);
    endtask
    // One read, data on OKAY only
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (int k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        rready <= 0;
        chk("rvalid", 1, rvalid);
        chk("rresp", er, rresp);
        if (er == OK) chk("rdata", exp, rdata);
    endtask
    task automatic wait_conv(input logic lvl);
        for (int k = 0; k < 200 && converting !== lvl; k++) @(posedge aclk);
        chk("converting", lvl, converting);
    endtask
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog
    initial begin
        #40000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd(C1, 32'h0000_0000, OK);
        rd(C2, 32'h0000_0000, OK);
        rd(8'h40, 32'h0000_0000, ER);
        wr(8'h40, 32'h0000_FFFF, ER);
        for (int i = 0; i < 8; i++) begin
            wr(C2, (i << 13) | ((i % 4) << 8), OK);
            repeat (2) @(posedge aclk);
            chk("ref_high", i == 1 || i == 3, rhi);
            chk("ref_low", i == 2 || i == 3, rlo);
            chk("channels", i % 4 == 0 ? 1 : i % 4 == 1 ? 2 : 4, chans);
        end
        wr(C1, 32'h0000_0400, OK);
        repeat (2) @(posedge aclk);
        chk("channels", 1, chans);
        wr(C1, 32'h0000_00E0, OK);
        repeat (10) @(posedge aclk);
        chk("sampling", 0, sampling);
        wr(C1, 32'h0000_0002, OK);
        rd(C1, 32'h0000_0002, OK);
        repeat (10) @(posedge aclk);
        chk("sampling", 1, sampling);
        wr(C1, 32'h0000_0000, OK);
        wait_conv(1);
        wait_conv(0);
        rd(C1, 32'h0000_0001, OK);
        rd(EV, 32'h0000_0003, OK);
        chk("irq", 0, irq);
        wr(MK, 32'h0000_0001, OK);
        repeat (2) @(posedge aclk);
        chk("irq", 1, irq);
        wr(EV, 32'h0000_0001, OK);
        repeat (2) @(posedge aclk);
        chk("irq", 0, irq);
        wr(C1, 32'h0000_0003, OK);
        rd(C1, 32'h0000_0003, OK);
        wr(C1, 32'h0000_0001, OK);
        wait_conv(1);
        rd(C1, 32'h0000_0000, OK);
        wait_conv(0);
        wr(C1, 32'h0000_0001, OK);
        rd(C1, 32'h0000_0001, OK);
        wr(C1, 32'h0000_0000, OK);
        rd(C1, 32'h0000_0000, OK);
        wr(C2, 32'h0000_0007, OK);
        wr(EV, 32'h0000_0003, OK);
        wr(C1, 32'h0000_00E4, OK);
        prev = 0;
        for (int n = 0; n < 4; n++) begin
            wait_conv(1);
            chk("input_set", !prev, sis);
            prev = sis;
            wait_conv(0);
            repeat (2) @(posedge aclk);
            chk("sampling", 1, sampling);
            if (n % 2 == 1) chk("buffer_half", n == 1, bh);
        end
        rd(EV, 32'h0000_0003, OK);
        stop_test();
    end
endmodule
`default_nettype wire
